// File: design/bsl_pkg.sv
/*
  bsl_pkg: shared constants, types and helpers for the bit-serial
  handshake link (word width, timing, state codes, padding alignment).
  assumes a 125 MHz system clock at both ends.
*/
package bsl_pkg;

  localparam int WORD_W        = 16;
  localparam int CNT_W         = $clog2(WORD_W + 1);
  localparam int TIMER_W       = 12;
  localparam int CLK_PERIOD_NS = 8;

  // minimum times, in ns as printed
  localparam int BIT_GAP_NS    = 10000;
  localparam int MEM_GAP_NS    = 4000;
  localparam int DEV_LOW_NS    = 1000;
  localparam int HOST_LOW_NS   = 50;
  localparam int DIST_LOW_NS   = 1000;

  // least times round up to whole cycles
  function automatic int ns_up(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int BIT_GAP_CYC   = ns_up(BIT_GAP_NS);
  localparam int MEM_GAP_CYC   = ns_up(MEM_GAP_NS);
  localparam int DEV_LOW_CYC   = ns_up(DEV_LOW_NS);
  localparam int HOST_LOW_CYC  = ns_up(HOST_LOW_NS);
  localparam int DIST_LOW_CYC  = ns_up(DIST_LOW_NS);

  localparam logic [WORD_W-1:0] PAD_WORD = 16'h8000;
  localparam logic [WORD_W-1:0] LSB_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0]  CNT_FULL = CNT_W'(WORD_W);
  localparam logic [CNT_W-1:0]  CNT_LAST = CNT_W'(WORD_W - 1);

  typedef enum logic [1:0] {
    RX_WAIT  = 2'b00,
    RX_STORE = 2'b01,
    RX_HOLD  = 2'b10
  } bsl_rx_state_type;

  typedef enum logic [1:0] {
    TX_FETCH = 2'b00,
    TX_AVAIL = 2'b01,
    TX_GAP   = 2'b10
  } bsl_tx_state_type;

  // move n received bits to the top of the word, optionally followed by a one
  function automatic logic [WORD_W-1:0] align(input logic [WORD_W-1:0] sh,
                                               input logic [CNT_W-1:0]  n,
                                               input logic              one);
    logic [WORD_W-1:0] w;
    w = sh << (CNT_FULL - n);
    if (one && n < CNT_FULL)
      w = w | (LSB_ONE << (CNT_LAST - n));
    return w;
  endfunction

endpackage

// File: design/bsl_link_if.sv
/*
  bsl_link_if: the wires between the device end and the host end.
  assumes both ends run on clocks of their own; every wire is a plain level.
*/
`timescale 1ns/100ps
interface bsl_link_if;
  // device to host direction
  logic out_data;
  logic out_strobe;
  logic end_of_message_out;
  logic out_request;
  // host to device direction
  logic in_data;
  logic in_strobe;
  logic end_of_message_in;
  logic in_request;

  modport device (
    output out_data, out_strobe, end_of_message_out, in_request,
    input  out_request, in_data, in_strobe, end_of_message_in
  );

  modport host (
    input  out_data, out_strobe, end_of_message_out, in_request,
    output out_request, in_data, in_strobe, end_of_message_in
  );
endinterface // bsl_link_if

// File: design/bsl_device.sv
/*
  bsl_device: device end of the link, one sending and one receiving
  section, each with its own 16-bit shift register and paced gaps.
  assumes link inputs may change at any time; they are synchronised here.
*/
// Functional notes
// - words go out high-order bit first, unmarked
// - bit moves only when available and requested
// - no fixed rate; either side may stall
// - on request fall: drop available, shift, reload
// - on strobe rise: capture bit, drop request
// - receiver raises request again when able
// - sender counts bits; receiver stores word first
// - four-way receiver waits for strobe low
// - sender drops strobe once request falls
// - two-way receiver holds request low briefly
// - host request low 50 ns or 1 us
// - fresh-bit flag set only by strobe rise
// - device request low at least 1 us
// - sender waits 10 us after each bit
// - request back up 10 us after strobe
// - word fetch or store adds 4 us
// - host keeps its own per-bit available flag
// - gaps adjustable; default 10 us per bit
// - host flags last bit with end_of_message_in
// - input pads one then zeros to fill
// - end_of_message_out with last padding bit
// - host fills final word with zeros
// - two independent 16-bit sections, full duplex
`timescale 1ns/100ps
module bsl_device #(
  parameter int BIT_GAP_CYC = bsl_pkg::BIT_GAP_CYC,
  parameter int MEM_GAP_CYC = bsl_pkg::MEM_GAP_CYC,
  parameter int DEV_LOW_CYC = bsl_pkg::DEV_LOW_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // link
  bsl_link_if.device                      link,
  // mode
  input  wire logic                       four_way,
  // words to send
  input  wire logic [bsl_pkg::WORD_W-1:0] tx_word,
  input  wire logic                       tx_last,
  input  wire logic                       tx_valid,
  output logic                            tx_ready,
  // words received
  output logic [bsl_pkg::WORD_W-1:0]      rx_word,
  output logic                            rx_last,
  output logic                            rx_valid,
  input  wire logic                       rx_ready
);

  localparam int HOLD_CYC = BIT_GAP_CYC > DEV_LOW_CYC ? BIT_GAP_CYC : DEV_LOW_CYC;
  localparam logic [bsl_pkg::TIMER_W-1:0] T_HOLD = bsl_pkg::TIMER_W'(HOLD_CYC);
  localparam logic [bsl_pkg::TIMER_W-1:0] T_HMEM = bsl_pkg::TIMER_W'(HOLD_CYC + MEM_GAP_CYC);
  localparam logic [bsl_pkg::TIMER_W-1:0] T_GAP  = bsl_pkg::TIMER_W'(BIT_GAP_CYC);
  localparam logic [bsl_pkg::TIMER_W-1:0] T_GMEM = bsl_pkg::TIMER_W'(BIT_GAP_CYC + MEM_GAP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: {request, strobe, data, eom}

  logic [3:0] meta;
  logic [3:0] sync;
  logic [3:0] prev;

  always_ff @(posedge clk) begin
    meta <= {link.out_request, link.in_strobe, link.in_data, link.end_of_message_in};
    sync <= meta;
    prev <= sync;
  end

  wire s_req   = sync[3];
  wire p_req   = prev[3];
  wire s_strb  = sync[2];
  wire p_strb  = prev[2];
  wire s_data  = sync[1];
  wire s_eom   = sync[0];
  // data and eom are stable well before the strobe, so equal latency is safe
  wire req_fall  = p_req & ~s_req;
  wire strb_rise = s_strb & ~p_strb;

  ////////////////////////////////////////////////////////////////////////////
  // sending section

  bsl_pkg::bsl_tx_state_type      tx_state;
  logic [bsl_pkg::WORD_W-1:0]     tx_sh;
  logic [bsl_pkg::CNT_W-1:0]      tx_cnt;
  logic [bsl_pkg::TIMER_W-1:0]    tx_tmr;
  logic                           tx_lastw;
  logic                           tx_avail;
  logic                           tx_sent;
  logic                           tx_eom;

  assign tx_ready                = tx_state == bsl_pkg::TX_FETCH;
  assign link.out_strobe         = tx_avail & s_req;
  assign link.out_data           = tx_sh[bsl_pkg::WORD_W-1];
  assign link.end_of_message_out = tx_eom;

  wire tx_taken    = tx_state == bsl_pkg::TX_AVAIL && tx_sent && req_fall;
  wire tx_word_end = tx_cnt == bsl_pkg::CNT_LAST;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state <= bsl_pkg::TX_FETCH;
      tx_sh    <= '0;
      tx_cnt   <= '0;
      tx_tmr   <= '0;
      tx_lastw <= 1'b0;
      tx_avail <= 1'b0;
      tx_sent  <= 1'b0;
      tx_eom   <= 1'b0;
    end else begin
      unique case (tx_state)
        bsl_pkg::TX_FETCH: begin
          if (tx_valid) begin
            tx_sh    <= tx_word;
            tx_lastw <= tx_last;
            tx_cnt   <= '0;
            tx_avail <= 1'b1;
            tx_sent  <= 1'b0;
            tx_state <= bsl_pkg::TX_AVAIL;
          end
        end
        bsl_pkg::TX_AVAIL: begin
          if (link.out_strobe)
            tx_sent <= 1'b1;
          if (tx_taken) begin
            tx_avail <= 1'b0;
            tx_sent  <= 1'b0;
            tx_sh    <= tx_sh << 1;
            tx_cnt   <= tx_cnt + 1'b1;
            tx_eom   <= tx_lastw && tx_cnt == bsl_pkg::CNT_W'(bsl_pkg::WORD_W - 2);
            tx_tmr   <= tx_word_end ? T_GMEM : T_GAP;
            tx_state <= bsl_pkg::TX_GAP;
          end
        end
        bsl_pkg::TX_GAP: begin
          if (tx_tmr != '0) begin
            tx_tmr <= tx_tmr - 1'b1;
          end else if (tx_cnt == bsl_pkg::CNT_FULL) begin
            tx_state <= bsl_pkg::TX_FETCH;
          end else begin
            tx_avail <= 1'b1;
            tx_state <= bsl_pkg::TX_AVAIL;
          end
        end
        default: tx_state <= bsl_pkg::TX_FETCH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiving section

  bsl_pkg::bsl_rx_state_type      rx_state;
  logic [bsl_pkg::WORD_W-1:0]     rx_sh;
  logic [bsl_pkg::CNT_W-1:0]      rx_cnt;
  logic [bsl_pkg::TIMER_W-1:0]    rx_tmr;
  logic [bsl_pkg::WORD_W-1:0]     st_word;
  logic                           st_last;
  logic                           st_pad;
  logic                           fresh_bit_seen;
  logic                           buf_in_ready;

  assign link.in_request = rx_state == bsl_pkg::RX_WAIT;

  wire                           rx_take = link.in_request & fresh_bit_seen;
  wire [bsl_pkg::WORD_W-1:0]     nsh     = {rx_sh[bsl_pkg::WORD_W-2:0], s_data};
  wire [bsl_pkg::CNT_W-1:0]      ncnt    = rx_cnt + 1'b1;
  wire                           nfull   = ncnt == bsl_pkg::CNT_FULL;
  wire                           push    = rx_state == bsl_pkg::RX_STORE && buf_in_ready;

  // stale strobe after a short low request is never a new bit
  always_ff @(posedge clk) begin
    if (sys_rst)
      fresh_bit_seen <= 1'b0;
    else if (strb_rise)
      fresh_bit_seen <= 1'b1;
    else if (rx_take)
      fresh_bit_seen <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state <= bsl_pkg::RX_WAIT;
      rx_sh    <= '0;
      rx_cnt   <= '0;
      rx_tmr   <= '0;
      st_word  <= '0;
      st_last  <= 1'b0;
      st_pad   <= 1'b0;
    end else begin
      unique case (rx_state)
        bsl_pkg::RX_WAIT: begin
          if (rx_take) begin
            rx_sh  <= nsh;
            rx_cnt <= nfull ? '0 : ncnt;
            if (s_eom) begin
              st_word  <= nfull ? nsh : bsl_pkg::align(nsh, ncnt, 1'b1);
              st_last  <= ~nfull;
              st_pad   <= nfull;
              rx_cnt   <= '0;
              rx_tmr   <= T_HMEM;
              rx_state <= bsl_pkg::RX_STORE;
            end else if (nfull) begin
              st_word  <= nsh;
              st_last  <= 1'b0;
              rx_tmr   <= T_HMEM;
              rx_state <= bsl_pkg::RX_STORE;
            end else begin
              rx_tmr   <= T_HOLD;
              rx_state <= bsl_pkg::RX_HOLD;
            end
          end
        end
        bsl_pkg::RX_STORE: begin
          if (rx_tmr != '0)
            rx_tmr <= rx_tmr - 1'b1;
          if (push) begin
            if (st_pad) begin
              st_word <= bsl_pkg::PAD_WORD;
              st_last <= 1'b1;
              st_pad  <= 1'b0;
            end else begin
              rx_state <= bsl_pkg::RX_HOLD;
            end
          end
        end
        bsl_pkg::RX_HOLD: begin
          if (rx_tmr != '0)
            rx_tmr <= rx_tmr - 1'b1;
          else if (!four_way || !s_strb)
            rx_state <= bsl_pkg::RX_WAIT;
        end
        default: rx_state <= bsl_pkg::RX_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry word buffer; a full buffer stalls the next word in store, which holds the request low

  logic [bsl_pkg::WORD_W:0] buf_mem [2];
  logic                     buf_wp;
  logic                     buf_rp;
  logic [1:0]               buf_cnt;

  wire pop = rx_valid & rx_ready;

  assign buf_in_ready = buf_cnt != 2'h2;
  assign rx_valid     = buf_cnt != 2'h0;
  assign rx_word      = buf_mem[buf_rp][bsl_pkg::WORD_W-1:0];
  assign rx_last      = buf_mem[buf_rp][bsl_pkg::WORD_W];

  always_ff @(posedge clk) begin
    if (push)
      buf_mem[buf_wp] <= {st_last, st_word};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buf_wp  <= 1'b0;
      buf_rp  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      buf_wp  <= buf_wp ^ push;
      buf_rp  <= buf_rp ^ pop;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // bsl_device

// File: design/bsl_host.sv
/*
  bsl_host: host end of the link, paced only by its minimum request low time (LOW_CYC).
  assumes the device end paces the stream; link inputs are synchronised here.
*/
`timescale 1ns/100ps
module bsl_host #(
  parameter int LOW_CYC = bsl_pkg::HOST_LOW_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // link
  bsl_link_if.host                        link,
  // mode
  input  wire logic                       four_way,
  // words to send
  input  wire logic [bsl_pkg::WORD_W-1:0] tx_word,
  input  wire logic                       tx_last,
  input  wire logic                       tx_valid,
  output logic                            tx_ready,
  // words received
  output logic [bsl_pkg::WORD_W-1:0]      rx_word,
  output logic                            rx_last,
  output logic                            rx_valid,
  input  wire logic                       rx_ready
);

  localparam logic [bsl_pkg::TIMER_W-1:0] T_LOW = bsl_pkg::TIMER_W'(LOW_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: {request, strobe, data, eom}

  logic [3:0] meta;
  logic [3:0] sync;
  logic [3:0] prev;

  always_ff @(posedge clk) begin
    meta <= {link.in_request, link.out_strobe, link.out_data, link.end_of_message_out};
    sync <= meta;
    prev <= sync;
  end

  wire req_fall  = prev[3] & ~sync[3];
  wire strb_rise = sync[2] & ~prev[2];

  ////////////////////////////////////////////////////////////////////////////
  // sending section

  bsl_pkg::bsl_tx_state_type  tx_state;
  logic [bsl_pkg::WORD_W-1:0] tx_sh;
  logic [bsl_pkg::CNT_W-1:0]  tx_cnt;
  logic                       tx_lastw;
  logic                       tx_avail;
  logic                       tx_sent;

  assign tx_ready               = tx_state == bsl_pkg::TX_FETCH;
  assign link.in_strobe         = tx_avail & sync[3];
  assign link.in_data           = tx_sh[bsl_pkg::WORD_W-1];
  // held with the bit until the request drops
  assign link.end_of_message_in = tx_lastw & (tx_cnt == bsl_pkg::CNT_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state <= bsl_pkg::TX_FETCH;
      tx_sh    <= '0;
      tx_cnt   <= '0;
      tx_lastw <= 1'b0;
      tx_avail <= 1'b0;
      tx_sent  <= 1'b0;
    end else begin
      unique case (tx_state)
        bsl_pkg::TX_FETCH: begin
          if (tx_valid) begin
            tx_sh    <= tx_word;
            tx_lastw <= tx_last;
            tx_cnt   <= '0;
            tx_avail <= 1'b1;
            tx_state <= bsl_pkg::TX_AVAIL;
          end
        end
        bsl_pkg::TX_AVAIL: begin
          if (link.in_strobe)
            tx_sent <= 1'b1;
          if (tx_sent && req_fall) begin
            tx_avail <= 1'b0;
            tx_sent  <= 1'b0;
            tx_sh    <= tx_sh << 1;
            tx_cnt   <= tx_cnt + 1'b1;
            tx_state <= bsl_pkg::TX_GAP;
          end
        end
        bsl_pkg::TX_GAP: begin
          if (tx_cnt == bsl_pkg::CNT_FULL) begin
            tx_state <= bsl_pkg::TX_FETCH;
          end else begin
            tx_avail <= 1'b1;
            tx_state <= bsl_pkg::TX_AVAIL;
          end
        end
        default: tx_state <= bsl_pkg::TX_FETCH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiving section

  bsl_pkg::bsl_rx_state_type   rx_state;
  logic [bsl_pkg::WORD_W-1:0]  rx_sh;
  logic [bsl_pkg::CNT_W-1:0]   rx_cnt;
  logic [bsl_pkg::TIMER_W-1:0] rx_tmr;
  logic                        fresh_bit_seen;

  assign link.out_request = rx_state == bsl_pkg::RX_WAIT;
  assign rx_valid         = rx_state == bsl_pkg::RX_STORE;

  wire                       rx_take = link.out_request & fresh_bit_seen;
  wire [bsl_pkg::WORD_W-1:0] nsh     = {rx_sh[bsl_pkg::WORD_W-2:0], sync[1]};
  wire [bsl_pkg::CNT_W-1:0]  ncnt    = rx_cnt + 1'b1;

  always_ff @(posedge clk) begin
    if (sys_rst)
      fresh_bit_seen <= 1'b0;
    else if (strb_rise)
      fresh_bit_seen <= 1'b1;
    else if (rx_take)
      fresh_bit_seen <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state <= bsl_pkg::RX_WAIT;
      rx_sh    <= '0;
      rx_cnt   <= '0;
      rx_tmr   <= '0;
      rx_word  <= '0;
      rx_last  <= 1'b0;
    end else begin
      unique case (rx_state)
        bsl_pkg::RX_WAIT: begin
          rx_tmr <= T_LOW;
          if (rx_take) begin
            rx_sh  <= nsh;
            rx_cnt <= ncnt;
            if (sync[0] || ncnt == bsl_pkg::CNT_FULL) begin
              rx_word  <= bsl_pkg::align(nsh, ncnt, 1'b0);
              rx_last  <= sync[0];
              rx_cnt   <= '0;
              rx_state <= bsl_pkg::RX_STORE;
            end else begin
              rx_state <= bsl_pkg::RX_HOLD;
            end
          end
        end
        bsl_pkg::RX_STORE: begin
          if (rx_tmr != '0)
            rx_tmr <= rx_tmr - 1'b1;
          if (rx_ready)
            rx_state <= bsl_pkg::RX_HOLD;
        end
        bsl_pkg::RX_HOLD: begin
          if (rx_tmr != '0)
            rx_tmr <= rx_tmr - 1'b1;
          else if (!four_way || !sync[2])
            rx_state <= bsl_pkg::RX_WAIT;
        end
        default: rx_state <= bsl_pkg::RX_WAIT;
      endcase
    end
  end

endmodule // bsl_host

// File: testbench/bsl_link_asserts.sv
/*
  bsl_link_asserts: handshake checks on the wires between device and host.
  assumes one clock for both ends and the interface signals as plain inputs.
*/
`timescale 1ns/100ps
module bsl_link_asserts #(
  parameter int BIT_GAP_CYC = bsl_pkg::BIT_GAP_CYC,
  parameter int MEM_GAP_CYC = bsl_pkg::MEM_GAP_CYC,
  parameter int DEV_LOW_CYC = bsl_pkg::DEV_LOW_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic four_way,
  // device to host
  input wire logic out_data,
  input wire logic out_strobe,
  input wire logic end_of_message_out,
  input wire logic out_request,
  // host to device
  input wire logic in_data,
  input wire logic in_strobe,
  input wire logic end_of_message_in,
  input wire logic in_request
);
  logic [15:0] gap_cnt;
  logic [15:0] low_cnt;
  logic [15:0] hold_cnt;
  logic [3:0]  bit_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // reset value large so the first bit after reset is not flagged
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_cnt <= 16'h0fff;
      low_cnt <= 16'h0fff;
      hold_cnt <= 16'h0fff;
      bit_cnt <= 4'h0;
    end else begin
      // bits taken by the host; zero again at every word boundary
      bit_cnt <= bit_cnt + {3'h0, $fell(out_request)};
      gap_cnt <= $fell(out_request) ? 16'h0000 : gap_cnt + 16'h0001;
      low_cnt <= in_request ? 16'h0000 : low_cnt + 16'h0001;
      hold_cnt <= $rose(in_strobe) ? 16'h0000 : hold_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  chk_out_strobe_req: assert property (out_strobe |-> $past(out_request, 2))
    else $error("out strobe without request");
  chk_in_strobe_req: assert property (in_strobe |-> $past(in_request, 2))
    else $error("in strobe without request");
  chk_out_data_hold: assert property (out_strobe && $past(out_strobe) |-> $stable(out_data))
    else $error("out data moved under strobe");
  chk_in_data_hold: assert property (in_strobe && $past(in_strobe) |-> $stable(in_data))
    else $error("in data moved under strobe");
  chk_out_strobe_drop: assert property ($fell(out_request) |-> ##[0:4] !out_strobe)
    else $error("out strobe kept after request fall");
  chk_in_strobe_drop: assert property ($fell(in_request) |-> ##[0:4] !in_strobe)
    else $error("in strobe kept after request fall");
  chk_dev_low_min: assert property ($rose(in_request) |-> low_cnt >= DEV_LOW_CYC)
    else $error("device request low too short");
  chk_dev_hold_gap: assert property ($rose(in_request) |-> hold_cnt >= BIT_GAP_CYC)
    else $error("device request back too early");
  chk_dev_send_gap: assert property ($rose(out_strobe) |-> gap_cnt >= BIT_GAP_CYC)
    else $error("device next bit too early");
  chk_dev_word_gap: assert property ($rose(out_strobe) && bit_cnt == 4'h0 |->
    gap_cnt >= BIT_GAP_CYC + MEM_GAP_CYC)
    else $error("device next word too early");
  chk_host_low_min: assert property ($fell(out_request) |-> !out_request [*7])
    else $error("host request low too short");
  chk_four_way_wait: assert property (four_way && $rose(in_request) |-> !$past(in_strobe))
    else $error("request raised under strobe");
  chk_eom_lead: assert property ($rose(end_of_message_out) |-> !$past(out_strobe))
    else $error("end of message after strobe");
endmodule // bsl_link_asserts

// File: testbench/bsl_link_tb.sv
/*
  bsl_link_tb: device end and host end joined by one link, both directions.
  assumes shortened device gaps; index 0 is the device, 1 the host.
*/
`timescale 1ns/100ps
module bsl_link_tb;
  typedef struct packed {logic [15:0] w; logic l;} bsl_row_type;
  localparam int GAP = 20;
  localparam int LOW = 4;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              four_way = 1'b0;
  logic              hold = 1'b0;
  logic [1:0]        tx_valid = 2'b00;
  logic [1:0]        tx_last = 2'b00;
  logic [1:0]        rx_ready = 2'b11;
  logic [1:0]        tx_ready;
  logic [1:0]        rx_last;
  logic [1:0]        rx_valid;
  logic [1:0]        next_rx_ready;
  logic [15:0]       tx_word [2] = '{16'h0000, 16'h0000};
  logic [15:0]       rx_word [2];
  logic [16:0]       exp_q [2][$];
  int                errors = 0;
  int                checks = 0;
  bsl_row_type       rows [4] = '{'{16'h8001, 1'b0}, '{16'ha5c3, 1'b1},
                                  '{16'hffff, 1'b1}, '{16'h0000, 1'b1}};

  always #4 clk = ~clk;
  assign next_rx_ready = hold ? 2'b00 : ~rx_ready;

  ////////////////////////////////////////////////////////////////////////
  bsl_link_if bsl_link_if_i ();
  bsl_device #(.BIT_GAP_CYC(GAP), .MEM_GAP_CYC(8), .DEV_LOW_CYC(LOW)) bsl_device_i (
    .clk(clk), .sys_rst(sys_rst), .link(bsl_link_if_i.device), .four_way(four_way),
    .tx_word(tx_word[0]), .tx_last(tx_last[0]), .tx_valid(tx_valid[0]), .tx_ready(tx_ready[0]),
    .rx_word(rx_word[0]), .rx_last(rx_last[0]), .rx_valid(rx_valid[0]), .rx_ready(rx_ready[0]));
  bsl_host bsl_host_i (
    .clk(clk), .sys_rst(sys_rst), .link(bsl_link_if_i.host), .four_way(four_way),
    .tx_word(tx_word[1]), .tx_last(tx_last[1]), .tx_valid(tx_valid[1]), .tx_ready(tx_ready[1]),
    .rx_word(rx_word[1]), .rx_last(rx_last[1]), .rx_valid(rx_valid[1]), .rx_ready(rx_ready[1]));
  bsl_link_asserts #(.BIT_GAP_CYC(GAP), .MEM_GAP_CYC(8), .DEV_LOW_CYC(LOW)) bsl_link_asserts_i (
    .clk(clk), .sys_rst(sys_rst), .four_way(four_way),
    .out_data(bsl_link_if_i.out_data), .out_strobe(bsl_link_if_i.out_strobe),
    .end_of_message_out(bsl_link_if_i.end_of_message_out),
    .out_request(bsl_link_if_i.out_request), .in_data(bsl_link_if_i.in_data),
    .in_strobe(bsl_link_if_i.in_strobe), .end_of_message_in(bsl_link_if_i.end_of_message_in),
    .in_request(bsl_link_if_i.in_request));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t flags %b expected %b", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // word handed over at the posedge after a negedge that sees ready
  task automatic send(input int s, input bsl_row_type r);
    @(negedge clk);
    tx_word[s] = r.w;
    tx_last[s] = r.l;
    tx_valid[s] = 1'b1;
    while (tx_ready[s] !== 1'b1) @(negedge clk);
    @(negedge clk);
    tx_valid[s] = 1'b0;
  endtask

  // device always sees whole words, so a last word draws a pad word
  task automatic expect_row(input bsl_row_type r);
    exp_q[1].push_back({r.w, r.l});
    exp_q[0].push_back({r.w, 1'b0});
    if (r.l)
      exp_q[0].push_back({16'h8000, 1'b1});
  endtask

  task automatic do_reset(input logic fw);
    @(negedge clk);
    sys_rst = 1'b1;
    four_way = fw;
    repeat (10) @(negedge clk);
    chk_flags({bsl_link_if_i.in_request, bsl_link_if_i.out_request, bsl_link_if_i.in_strobe,
               bsl_link_if_i.out_strobe, tx_ready, rx_valid}, 8'hcc);
    sys_rst = 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q[0].size() + exp_q[1].size() != 0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    // a run-out limit is a failure, not a silent pass
    if (n >= 20000) begin
      errors++;
      $display("MISMATCH %0t words still expected", $time);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // receivers stall every other cycle; compare what the next posedge takes
  always @(negedge clk) begin
    for (int s = 0; s < 2; s++) begin
      if (rx_valid[s] === 1'b1 && next_rx_ready[s])
        chk_word({rx_word[s], rx_last[s]},
                 exp_q[s].size() != 0 ? exp_q[s].pop_front() : {1'bx, 16'hxxxx});
    end
    rx_ready <= next_rx_ready;
  end

  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      foreach (rows[i]) begin
        expect_row(rows[i]);
        fork
          send(0, rows[i]);
          send(1, rows[i]);
        join
      end
      drain();
    end
    // abort mid-word: nothing may arrive after the second reset
    do_reset(1'b0);
    send(1, rows[1]);
    repeat (100) @(negedge clk);
    do_reset(1'b0);
    // both receivers stall long: device buffer fills and request stays low
    hold = 1'b1;
    for (int i = 0; i < 3; i++)
      expect_row(rows[i]);
    fork
      for (int i = 0; i < 3; i++) send(0, rows[i]);
      for (int i = 0; i < 3; i++) send(1, rows[i]);
      begin
        repeat (3000) @(negedge clk);
        chk_flags({6'h00, rx_valid[0], bsl_link_if_i.in_request}, 8'h02);
        hold = 1'b0;
      end
    join
    drain();
    print_verdict();
  end
endmodule // bsl_link_tb
